// >>> logic/cpfe_map.vh
/*
 Constants of the processor pin front end: reset address, bus phases,
 interrupt type and wake delay figures.
 Assumes inclusion by the front end modules only.
*/
`ifndef CPFE_MAP_VH
`define CPFE_MAP_VH
`define CPFE_RESET_ADDR 20'hffff0
`define CPFE_NMI_TYPE 8'h02
`define CPFE_ADDR_W 20
`define CPFE_DATA_W 16
`define CPFE_CLK_NS 100
`define CPFE_WAKE_MIN_NS 1000
`define CPFE_WAKE_CYC ((`CPFE_WAKE_MIN_NS + `CPFE_CLK_NS - 1) / `CPFE_CLK_NS)
`define CPFE_PH_IDLE 4'h1
`define CPFE_PH_ADDR 4'h2
`define CPFE_PH_DATA 4'h4
`define CPFE_PH_END 4'h8
`endif

// >>> logic/cpfe_sync.v
/*
 Two-flop synchroniser for a group of asynchronous inputs.
 Assumes the inputs are free of glitches wider than one clock.
*/
`timescale 1ns/10ps
module cpfe_sync #(
  parameter W = 1,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst_b,
  // Data
  input wire [W-1:0] async_in,
  output reg [W-1:0] sync_out
);
  reg [W-1:0] meta;

  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta <= INIT;
      sync_out <= INIT;
    end
    else
    begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule

// >>> logic/cpfe_half_clk.v
/*
 Divides the double rate clock by two on its falling edge.
 Assumes the reset release is already aligned to the double rate clock.
*/
`timescale 1ns/10ps
module cpfe_half_clk (
  // Clock and reset
  input wire double_rate_clock_in,
  input wire rst_b,
  // Divided clock
  output reg half_rate_clock_out
);
  // Reset holds the phase so the first half cycle after release is aligned.
  always @(negedge double_rate_clock_in or negedge rst_b)
  begin
    if (!rst_b)
      half_rate_clock_out <= 1'b0;
    else
      half_rate_clock_out <= ~half_rate_clock_out;
  end
endmodule

// >>> logic/cpfe_front.v
/*
 Pin front end of a 16-bit embedded processor: reset sequencing, start
 address, coprocessor strap, wait-for-test, latched unmaskable interrupt,
 wake delay, and the multiplexed local bus address and data phases.
 Assumes a core that requests bus cycles with a one-cycle start pulse and
 holds address and data stable until cycle_done.
*/
`timescale 1ns/10ps
`include "cpfe_map.vh"
module cpfe_front #(
  parameter NARROW_BUS = 0
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst_b,
  input wire double_rate_clock_in,
  // Pins
  input wire reset_request_in_b,
  input wire test_busy_in_b,
  input wire nmi_in,
  input wire wake_delay_timer_pin,
  input wire all_pins_float_test_mode_b,
  output reg half_rate_clock_out,
  output reg crystal_drive_out,
  output reg reset_indicator_out,
  output reg address_latch_strobe,
  output reg [15:0] addr_data_out,
  output reg [15:0] addr_data_oe_b,
  input wire [15:0] addr_data_in,
  output reg [2:0] upper_address_lines,
  output reg addr19_cycle_source_pin,
  output reg bus_pins_oe_b,
  // Core side
  input wire cycle_start,
  input wire cycle_write,
  input wire cycle_dma,
  input wire [19:0] cycle_addr,
  input wire [15:0] cycle_wdata,
  input wire wait_for_test,
  input wire deep_sleep,
  input wire nmi_ack,
  output reg cycle_done,
  output reg [15:0] cycle_rdata,
  output reg [19:0] start_addr,
  output reg core_run,
  output reg coproc_mode,
  output reg wait_stall,
  output reg nmi_pending,
  output reg [7:0] nmi_type
);
  wire [4:0] raw_in;
  wire [4:0] syn;
  wire half_clk;
  wire reset_request_in_s;
  wire test_s;
  wire nmi_s;
  wire wake_s;
  wire float_s;
  reg nmi_prev;
  reg in_reset;
  reg sleeping;
  reg wake_wait;
  reg [3:0] phase;
  reg [3:0] next_phase;
  reg [19:0] lat_addr;
  reg lat_write;
  reg lat_dma;
  reg [15:0] lat_wdata;
  reg [7:0] wake_cnt;

  localparam integer WAKE_CYC_I = `CPFE_WAKE_CYC;
  localparam [7:0] WAKE_CYC = WAKE_CYC_I[7:0];

  assign raw_in = {all_pins_float_test_mode_b, wake_delay_timer_pin, nmi_in,
                   test_busy_in_b, reset_request_in_b};

  // Every asynchronous pin is resynchronised before any decision, except reset_request_in_b, which also resets the divider directly.
  cpfe_sync #(.W(5), .INIT(5'h1a)) u_sync (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .async_in(raw_in),
    .sync_out(syn)
  );
  assign reset_request_in_s = syn[0];
  assign test_s = syn[1];
  assign nmi_s = syn[2];
  assign wake_s = syn[3];
  assign float_s = ~syn[4];

  cpfe_half_clk u_half (
    .double_rate_clock_in(double_rate_clock_in),
    .rst_b(reset_request_in_b & rst_b),
    .half_rate_clock_out(half_clk)
  );

  // The divided clock leaves through one flop, trading a cycle of skew.
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      half_rate_clock_out <= 1'b0;
      crystal_drive_out <= 1'b0;
    end
    else
    begin
      half_rate_clock_out <= half_clk;
      crystal_drive_out <= ~crystal_drive_out;
    end
  end

  always @*
  begin
    next_phase = phase;
    case (phase)
      `CPFE_PH_IDLE:
        if (cycle_start && core_run && !float_s)
          next_phase = `CPFE_PH_ADDR;
      `CPFE_PH_ADDR:
        next_phase = `CPFE_PH_DATA;
      `CPFE_PH_DATA:
        next_phase = `CPFE_PH_END;
      `CPFE_PH_END:
        next_phase = `CPFE_PH_IDLE;
      default:
        next_phase = `CPFE_PH_IDLE;
    endcase
    if (in_reset || !reset_request_in_s)
      next_phase = `CPFE_PH_IDLE;
  end

  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      in_reset <= 1'b1;
      reset_indicator_out <= 1'b1;
      coproc_mode <= 1'b0;
      start_addr <= `CPFE_RESET_ADDR;
      core_run <= 1'b0;
      wait_stall <= 1'b0;
      nmi_prev <= 1'b0;
      nmi_pending <= 1'b0;
      nmi_type <= 8'h00;
      sleeping <= 1'b0;
      wake_wait <= 1'b0;
      wake_cnt <= 8'h00;
    end
    else
    begin
      reset_indicator_out <= ~reset_request_in_s;
      in_reset <= ~reset_request_in_s;
      if (!reset_request_in_s)
      begin
        // Strap sampled while reset holds; a low test pin sets coproc_mode, and a tied indicator reads high.
        coproc_mode <= ~test_s;
        start_addr <= `CPFE_RESET_ADDR;
        core_run <= 1'b0;
        wait_stall <= 1'b0;
        nmi_pending <= 1'b0;
        sleeping <= 1'b0;
        wake_wait <= 1'b0;
      end
      else
      begin
        core_run <= ~sleeping & ~wake_wait & ~wait_stall;
        // In coprocessor mode the pin is busy, handled by the core.
        if (wait_for_test && !coproc_mode && test_s)
          wait_stall <= 1'b1;
        else if (!test_s)
          wait_stall <= 1'b0;
        // A new edge wins over the acknowledge in the same cycle.
        if (nmi_s && !nmi_prev)
          nmi_pending <= 1'b1;
        else if (nmi_ack)
          nmi_pending <= 1'b0;
        nmi_type <= `CPFE_NMI_TYPE;
        if (deep_sleep && !sleeping)
          sleeping <= 1'b1;
        else if (sleeping && !deep_sleep)
        begin
          sleeping <= 1'b0;
          wake_wait <= 1'b1;
          wake_cnt <= 8'h00;
        end
        // Wake needs the timer pin high and a floor count for the oscillator.
        if (wake_wait)
        begin
          if (wake_cnt < WAKE_CYC)
            wake_cnt <= wake_cnt + 8'h01;
          else if (wake_s)
            wake_wait <= 1'b0;
        end
      end
      nmi_prev <= nmi_s;
    end
  end

  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      phase <= `CPFE_PH_IDLE;
      lat_addr <= 20'h00000;
      lat_write <= 1'b0;
      lat_dma <= 1'b0;
      lat_wdata <= 16'h0000;
      address_latch_strobe <= 1'b0;
      addr_data_out <= 16'h0000;
      addr_data_oe_b <= 16'hffff;
      upper_address_lines <= 3'h0;
      addr19_cycle_source_pin <= 1'b0;
      bus_pins_oe_b <= 1'b1;
      cycle_done <= 1'b0;
      cycle_rdata <= 16'h0000;
    end
    else
    begin
      phase <= next_phase;
      cycle_done <= 1'b0;
      address_latch_strobe <= 1'b0;
      if (phase == `CPFE_PH_IDLE && next_phase == `CPFE_PH_ADDR)
      begin
        lat_addr <= cycle_addr;
        lat_write <= cycle_write;
        lat_dma <= cycle_dma;
        lat_wdata <= cycle_wdata;
      end
      if (in_reset || !reset_request_in_s || float_s)
      begin
        // Bus floats in reset and test mode; cycle in flight is dropped.
        addr_data_oe_b <= 16'hffff;
        bus_pins_oe_b <= 1'b1;
        addr_data_out <= 16'h0000;
        upper_address_lines <= 3'h0;
        addr19_cycle_source_pin <= 1'b0;
      end
      else
      begin
        case (next_phase)
          `CPFE_PH_ADDR:
          begin
            address_latch_strobe <= 1'b1;
            bus_pins_oe_b <= 1'b0;
            addr_data_oe_b <= 16'h0000;
            addr_data_out <= cycle_addr[15:0];
            upper_address_lines <= cycle_addr[18:16];
            addr19_cycle_source_pin <= cycle_addr[19];
          end
          `CPFE_PH_DATA, `CPFE_PH_END:
          begin
            upper_address_lines <= 3'h0;
            addr19_cycle_source_pin <= lat_dma;
            if (NARROW_BUS != 0)
            begin
              addr_data_out <= {lat_addr[15:8], lat_wdata[7:0]};
              addr_data_oe_b <= {8'h00, {8{~lat_write}}};
            end
            else
            begin
              addr_data_out <= lat_wdata;
              addr_data_oe_b <= {16{~lat_write}};
            end
            if (phase == `CPFE_PH_DATA)
            begin
              cycle_done <= 1'b1;
              cycle_rdata <= (NARROW_BUS != 0) ? {8'h00, addr_data_in[7:0]} : addr_data_in;
            end
          end
          default:
          begin
            addr_data_oe_b <= 16'hffff;
            bus_pins_oe_b <= 1'b1;
          end
        endcase
      end
    end
  end
endmodule

// >>> test/cpfe_front_assertions.sv
/* Checker for the bus and reset pins of the processor pin front end.
   Assumes it is bound to cpfe_front and clocked by ref_clk. */
`timescale 1ns/10ps
module cpfe_front_assertions (
  // Clock and reset
  input wire ref_clk,
  input wire rst_b,
  // Watched pins and core side
  input wire reset_request_in_b,
  input wire crystal_drive_out,
  input wire reset_indicator_out,
  input wire address_latch_strobe,
  input wire [15:0] addr_data_out,
  input wire [15:0] addr_data_oe_b,
  input wire [2:0] upper_address_lines,
  input wire addr19_cycle_source_pin,
  input wire cycle_dma,
  input wire [19:0] cycle_addr,
  input wire cycle_done
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  sequence s_addr_ph;
    addr_data_oe_b == 16'h0000 && addr_data_out == cycle_addr[15:0]
      && {addr19_cycle_source_pin, upper_address_lines} == cycle_addr[19:16];
  endsequence
  sequence s_data_ph;
    upper_address_lines == 3'h0 && addr19_cycle_source_pin == cycle_dma;
  endsequence
  a_addr_phase: assert property (address_latch_strobe |-> s_addr_ph)
    else $error("address phase pins wrong");
  a_data_phase: assert property (address_latch_strobe |=> s_data_ph)
    else $error("data phase pins wrong");
  a_strobe_pulse: assert property (address_latch_strobe |=> !address_latch_strobe)
    else $error("strobe longer than one cycle");
  a_done_timing: assert property (address_latch_strobe |-> ##2 cycle_done)
    else $error("cycle end late");
  a_bus_release: assert property (cycle_done |=> addr_data_oe_b == 16'hffff)
    else $error("bus not released");
  a_crystal_runs: assert property ($past(rst_b) |-> crystal_drive_out != $past(crystal_drive_out))
    else $error("crystal drive stalled");
  a_reset_hold: assert property (!reset_request_in_b [*4] |-> reset_indicator_out)
    else $error("reset indicator low in reset");
  a_reset_float: assert property (!reset_request_in_b [*4] |-> &addr_data_oe_b)
    else $error("bus driven in reset");
  a_reset_drop: assert property (reset_request_in_b [*4] |-> !reset_indicator_out)
    else $error("reset indicator stuck");
endmodule
bind cpfe_front cpfe_front_assertions chk_u (.ref_clk, .rst_b, .reset_request_in_b,
  .crystal_drive_out, .reset_indicator_out, .address_latch_strobe, .addr_data_out,
  .addr_data_oe_b, .upper_address_lines, .addr19_cycle_source_pin, .cycle_dma,
  .cycle_addr, .cycle_done);

// >>> test/cpfe_bus_mem.sv
/* Memory on the far side of the multiplexed local bus.
   Assumes a one-cycle address strobe and a two-cycle data phase. */
`timescale 1ns/10ps
module cpfe_bus_mem (
  // Clock and reset
  input wire ref_clk,
  input wire rst_b,
  // Local bus
  input wire address_latch_strobe,
  input wire [15:0] addr_data_out,
  input wire [15:0] addr_data_oe_b,
  output wire [15:0] addr_data_in
);
  logic [15:0] lat;
  logic [15:0] idle_word;
  logic [1:0] rd;
  // A floating bus must not look like held data, so idle cycles show a toggling word.
  assign addr_data_in = (rd != 2'h0 && &addr_data_oe_b) ? lat ^ 16'h5a5a : idle_word;
  always @(posedge ref_clk or negedge rst_b)
    if (!rst_b)
    begin
      lat <= 16'h0000;
      idle_word <= 16'h0f0f;
      rd <= 2'h0;
    end
    else
    begin
      idle_word <= ~idle_word;
      rd <= address_latch_strobe ? 2'h2 : (rd == 2'h0 ? 2'h0 : rd - 2'h1);
      if (address_latch_strobe)
        lat <= addr_data_out;
    end
endmodule

// >>> test/cpfe_front_bench.sv
/* Bench for the processor pin front end with a memory on the local bus.
   Assumes the design and the memory model are compiled first. */
`timescale 1ns/10ps
module cpfe_front_bench;
  logic ref_clk = 1'h0, rst_b = 1'h0, double_rate_clock_in = 1'h0;
  logic reset_request_in_b = 1'h0, test_busy_in_b = 1'h1, nmi_in = 1'h0, nmi_ack = 1'h0;
  logic wake_delay_timer_pin = 1'h1, all_pins_float_test_mode_b = 1'h1, deep_sleep = 1'h0;
  logic cycle_start = 1'h0, cycle_write = 1'h0, cycle_dma = 1'h0, wait_for_test = 1'h0;
  logic [19:0] cycle_addr = 20'h0;
  logic [15:0] cycle_wdata = 16'h0;
  wire half_rate_clock_out, crystal_drive_out, reset_indicator_out, address_latch_strobe;
  wire addr19_cycle_source_pin, bus_pins_oe_b, cycle_done, core_run, coproc_mode;
  wire wait_stall, nmi_pending;
  wire [2:0] upper_address_lines;
  wire [7:0] nmi_type;
  wire [15:0] addr_data_out, addr_data_oe_b, addr_data_in, cycle_rdata;
  wire [19:0] start_addr;
  int n_fail = 0;
  int cmp_count = 0;
  int cyc = 0;
  cpfe_front dut_u (.*);
  cpfe_bus_mem mem_u (.*);
  initial forever #50 ref_clk = ~ref_clk;
  initial forever #25 double_rate_clock_in = ~double_rate_clock_in;
  task tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // Sampling 1 ns after the edge lets that edge's updates land first.
  task look(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task stop_test;
    $display("mismatches %0d, compares %0d", n_fail, cmp_count);
    if (n_fail == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task t_reset;
    look(6);
    chk(reset_indicator_out, 1'h1);
    chk(addr_data_oe_b, 16'hffff);
    tick(1);
    reset_request_in_b <= 1'h1;
    look(6);
    chk(reset_indicator_out, 1'h0);
    chk(core_run, 1'h1);
    chk(start_addr, 20'hffff0);
    chk(coproc_mode, 1'h0);
  endtask
  task t_bus(input logic w, input logic d, input logic [19:0] a, input logic [15:0] wd);
    tick(1);
    cycle_start <= 1'h1;
    cycle_write <= w;
    cycle_dma <= d;
    cycle_addr <= a;
    cycle_wdata <= wd;
    tick(1);
    cycle_start <= 1'h0;
    #1;
    chk(address_latch_strobe, 1'h1);
    chk(addr_data_out, a[15:0]);
    chk({addr19_cycle_source_pin, upper_address_lines}, a[19:16]);
    look(1);
    chk({addr19_cycle_source_pin, upper_address_lines}, {d, 3'h0});
    chk(w ? addr_data_out : addr_data_oe_b, w ? wd : 16'hffff);
    look(1);
    chk(cycle_done, 1'h1);
    if (!w)
      chk(cycle_rdata, a[15:0] ^ 16'h5a5a);
  endtask
  task t_nmi;
    tick(1);
    nmi_in <= 1'h1;
    look(5);
    chk({nmi_pending, nmi_type}, 9'h102);
    tick(1);
    nmi_in <= 1'h0;
    nmi_ack <= 1'h1;
    tick(1);
    nmi_ack <= 1'h0;
    look(3);
    chk(nmi_pending, 1'h0);
  endtask
  task t_wait;
    tick(1);
    wait_for_test <= 1'h1;
    look(4);
    chk(wait_stall, 1'h1);
    tick(1);
    test_busy_in_b <= 1'h0;
    look(5);
    chk(wait_stall, 1'h0);
    tick(1);
    wait_for_test <= 1'h0;
    test_busy_in_b <= 1'h1;
  endtask
  // The core must stay halted through the wake floor until the timer pin reports ready.
  task t_wake;
    tick(1);
    deep_sleep <= 1'h1;
    wake_delay_timer_pin <= 1'h0;
    look(3);
    chk(core_run, 1'h0);
    tick(1);
    deep_sleep <= 1'h0;
    look(20);
    chk(core_run, 1'h0);
    tick(1);
    wake_delay_timer_pin <= 1'h1;
    look(6);
    chk(core_run, 1'h1);
  endtask
  // The bench drives the test pin low along with the reset request pin, so test follows reset here.
  task t_strap;
    tick(1);
    reset_request_in_b <= 1'h0;
    test_busy_in_b <= 1'h0;
    tick(4);
    cycle_start <= 1'h1;
    tick(1);
    cycle_start <= 1'h0;
    #1;
    chk(address_latch_strobe, 1'h0);
    tick(1);
    reset_request_in_b <= 1'h1;
    look(6);
    chk(coproc_mode, 1'h1);
    tick(1);
    test_busy_in_b <= 1'h1;
  endtask
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      n_fail++;
      stop_test;
    end
  end
  initial
  begin
    tick(10);
    rst_b <= 1'h1;
    t_reset;
    t_bus(1'h1, 1'h1, 20'hfedcb, 16'h1234);
    t_bus(1'h0, 1'h0, 20'h7a5c3, 16'h0000);
    t_bus(1'h0, 1'h0, 20'hffff0, 16'h0000);
    t_nmi;
    t_wait;
    t_wake;
    t_strap;
    stop_test;
  end
endmodule
